// file: verif/scpi_status_capture_ctrl_checker.sv
/*
  Concurrent checks on the ports of the status and capture controller.
  Assumes binding to the design top module, one clock, async reset.
*/
`timescale 1ns/1ns
`default_nettype none

`include "scpi_status_capture_ctrl_regs.svh"

module scpi_status_capture_ctrl_checker
  import scpi_status_capture_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device side
  input wire logic self_test_start,
  input wire logic stream_stopped,
  input wire logic sweep_stopped,
  input wire logic [1:0] capture_mode,
  input wire logic trigger_enable,
  input wire logic capture_stop,
  input wire logic defaults_restore,
  input wire logic buffer_flush
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence s_take;
    psel && penable && pready;
  endsequence

  sequence s_cmd(logic [4:0] c);
    s_take ##0 (pwrite && paddr == `OFS_COMMAND && pwdata[4:0] == c);
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_unmapped_err: assert property (s_take ##0 (paddr > `OFS_NET_PORT) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_port_read: assert property (s_take ##0 (!pwrite && paddr == `OFS_NET_PORT) |-> prdata == 32'd37001)
    else $error("port number wrong");
  a_abort_pulse: assert property (s_cmd(CMD_ABORT) |-> ##[0:2] capture_stop)
    else $error("abort gave no stop pulse");
  a_abort_manual: assert property (s_cmd(CMD_ABORT) |-> ##2 (capture_mode == MODE_BLOCK && !trigger_enable))
    else $error("abort left capture running");
  a_reset_flush: assert property (s_cmd(CMD_RESET) |-> ##[0:2] (defaults_restore && buffer_flush))
    else $error("reset gave no restore and flush");
  a_reset_block: assert property (s_cmd(CMD_RESET) |-> ##2 (capture_mode == MODE_BLOCK && !trigger_enable))
    else $error("reset left mode or trigger");
  a_test_start: assert property (s_cmd(CMD_SELF_TEST_Q) |-> ##[0:2] self_test_start)
    else $error("self-test not started");
  a_mode_legal: assert property (capture_mode != 2'b11)
    else $error("illegal capture mode");
  a_stop_block: assert property ((stream_stopped && capture_mode == MODE_STREAMING) ||
    (sweep_stopped && capture_mode == MODE_SWEEPING) |-> ##2 capture_mode == MODE_BLOCK)
    else $error("no fall back to block");
endmodule : scpi_status_capture_ctrl_checker

`default_nettype wire

// file: verif/scpi_status_capture_ctrl_tb.sv
/*
  Testbench: APB command and query sequences with expected answers.
  Assumes the design, its package, header and the self-test model.
*/
`timescale 1ns/1ns
`default_nettype none

`include "scpi_status_capture_ctrl_regs.svh"

module scpi_status_capture_ctrl_tb
  import scpi_status_capture_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, op_pending = 0, error_event = 0, quest_event = 0, oper_event = 0;
  logic [7:1] event_in = 0;
  logic self_test_start, self_test_done, self_test_fail, fail_level = 0, e;
  logic stream_stopped = 0, sweep_stopped = 0, trigger_enable, capture_stop;
  logic defaults_restore, buffer_flush, service_request;
  logic [1:0] capture_mode;
  int errors = 0, n_checks = 0;
  // Identity values are arbitrary
  logic [31:0] ident[4] = '{32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 32'h0000_4444};

  scpi_status_capture_ctrl #(.IDENT_MAKER(32'h0000_1111), .IDENT_MODEL(32'h0000_2222),
    .IDENT_SERIAL(32'h0000_3333), .IDENT_FIRMWARE(32'h0000_4444)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_pending(op_pending), .event_in(event_in), .error_event(error_event),
    .quest_event(quest_event), .oper_event(oper_event), .self_test_start(self_test_start),
    .self_test_done(self_test_done), .self_test_fail(self_test_fail),
    .stream_stopped(stream_stopped), .sweep_stopped(sweep_stopped), .capture_mode(capture_mode),
    .trigger_enable(trigger_enable), .capture_stop(capture_stop),
    .defaults_restore(defaults_restore), .buffer_flush(buffer_flush),
    .service_request(service_request));

  self_test_model model (.pclk(pclk), .presetn(presetn), .self_test_start(self_test_start),
    .fail_level(fail_level), .self_test_done(self_test_done), .self_test_fail(self_test_fail));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic cmd(input command_type c, input logic [7:0] arg);
    xfer(1'b1, `OFS_COMMAND, {16'h0000, arg, 3'b000, c});
  endtask : cmd

  task automatic query(input command_type c, input logic [7:0] arg);
    cmd(c, arg);
    xfer(1'b0, `OFS_RESPONSE, 32'h0);
  endtask : query

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle

  task automatic drop_pending();
    fork
      begin
        repeat (20) @(posedge pclk);
        op_pending <= 1'b0;
      end
    join_none
  endtask : drop_pending

  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Clock, watchdog, tests
  // ---------------------------------------------------------------
  initial forever #50 pclk = ~pclk;

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `OFS_STATUS, 0); chk("status", 32'h0, r);
    xfer(1'b0, `OFS_NET_PORT, 0); chk("port", 32'd37001, r);
    xfer(1'b0, 12'h100, 0); chk("unmapped", 32'h1, {r[30:0], e});
    query(CMD_IDENT_Q, 0); chk("idn", 32'h4, r);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, `OFS_IDENT_MAKER + 12'(4 * i), 0); chk("ident", ident[i], r);
    end
    cmd(CMD_EVENT_ENABLE, 8'hFF); query(CMD_EVENT_ENABLE_Q, 0); chk("ese", 32'hFF, r);
    cmd(CMD_EVENT_ENABLE, 8'h84);
    event_in <= 7'h41; @(posedge pclk); event_in <= 7'h00; settle();
    xfer(1'b0, `OFS_STATUS, 0); chk("esb", 32'h20, r & 32'h20);
    xfer(1'b0, `OFS_EVENT_STATUS, 0); chk("esr", 32'h80, r);
    xfer(1'b0, `OFS_EVENT_STATUS, 0); chk("esr", 32'h80, r);
    query(CMD_EVENT_STATUS_Q, 0); chk("esr?", 32'h80, r);
    query(CMD_EVENT_STATUS_Q, 0); chk("esr?", 32'h0, r);
    cmd(CMD_SERVICE_ENABLE, 8'h20); query(CMD_SERVICE_ENABLE_Q, 0); chk("sre", 32'h20, r);
    event_in <= 7'h40; @(posedge pclk); event_in <= 7'h00; settle();
    chk("srq", 32'h1, {31'h0, service_request});
    for (int i = 0; i < 2; i++) begin
      query(CMD_STATUS_BYTE_Q, 0); chk("stb?", 32'h20, r & 32'h20);
    end
    error_event <= 1; quest_event <= 1; oper_event <= 1; @(posedge pclk);
    error_event <= 0; quest_event <= 0; oper_event <= 0; settle();
    xfer(1'b0, `OFS_STATUS, 0); chk("stb", 32'h8C, r & 32'h8C);
    cmd(CMD_CLEAR_STATUS, 0); settle();
    xfer(1'b0, `OFS_STATUS, 0); chk("cls", 32'h0, r & 32'hFF);
    xfer(1'b0, `OFS_EVENT_STATUS, 0); chk("cls esr", 32'h0, r);
    chk("cls srq", 32'h0, {31'h0, service_request});
    cmd(CMD_EVENT_ENABLE, 8'h01);
    cmd(CMD_START_STREAM, 0); cmd(CMD_TRIGGER_ON, 0); settle();
    chk("mode", 32'h5, {29'h0, trigger_enable, capture_mode});
    cmd(CMD_RESET, 0); settle();
    chk("rst", 32'h0, {29'h0, trigger_enable, capture_mode});
    query(CMD_EVENT_ENABLE_Q, 0); chk("rst ese", 32'h1, r);
    xfer(1'b0, `OFS_SERVICE_ENABLE, 0); chk("rst sre", 32'h20, r);
    cmd(CMD_START_SWEEP, 0); cmd(CMD_TRIGGER_ON, 0); settle();
    chk("sweep", 32'h6, {29'h0, trigger_enable, capture_mode});
    cmd(CMD_ABORT, 0); settle();
    chk("abort", 32'h0, {29'h0, trigger_enable, capture_mode});
    for (int i = 1; i < 3; i++) begin
      cmd(i == 1 ? CMD_START_STREAM : CMD_START_SWEEP, 0);
      query(CMD_CAPTURE_MODE_Q, 0); chk("mode?", i, r);
      stream_stopped <= (i == 1); sweep_stopped <= (i == 2); @(posedge pclk);
      stream_stopped <= 0; sweep_stopped <= 0; settle();
      chk("stop", 32'h0, {30'h0, capture_mode});
    end
    op_pending <= 1; cmd(CMD_OP_COMPLETE, 0); settle();
    xfer(1'b0, `OFS_EVENT_STATUS, 0); chk("opc early", 32'h0, r);
    op_pending <= 0; settle();
    xfer(1'b0, `OFS_EVENT_STATUS, 0); chk("opc", 32'h1, r);
    query(CMD_EVENT_STATUS_Q, 0);
    op_pending <= 1; cmd(CMD_OP_COMPLETE_Q, 0); drop_pending();
    xfer(1'b0, `OFS_RESPONSE, 0); chk("opc? wait", 32'h0, {31'h0, op_pending});
    chk("opc?", 32'h31, r);
    op_pending <= 1; cmd(CMD_WAIT, 0); drop_pending();
    query(CMD_EVENT_ENABLE_Q, 0); chk("wai", 32'h0, {31'h0, op_pending});
    chk("wai ese", 32'h1, r);
    for (int i = 0; i < 2; i++) begin
      fail_level <= i[0];
      query(CMD_SELF_TEST_Q, 0); chk("tst", i, r);
    end
    summarize();
  end
endmodule : scpi_status_capture_ctrl_tb

bind scpi_status_capture_ctrl scpi_status_capture_ctrl_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .self_test_start(self_test_start), .stream_stopped(stream_stopped),
  .sweep_stopped(sweep_stopped), .capture_mode(capture_mode), .trigger_enable(trigger_enable),
  .capture_stop(capture_stop), .defaults_restore(defaults_restore), .buffer_flush(buffer_flush));

`default_nettype wire

// file: verif/self_test_model.sv
/*
  Model of the self-test engine behind the controller.
  Assumes a start pulse; answers after a set delay with the commanded level.
*/
`timescale 1ns/1ns
`default_nettype none

module self_test_model #(
  parameter int TEST_CYCLES = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Test control
  input wire logic self_test_start,
  input wire logic fail_level,
  output logic self_test_done,
  output logic self_test_fail
);
  int cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      self_test_done <= 1'b0;
      self_test_fail <= 1'b0;
    end else begin
      self_test_done <= 1'b0;
      self_test_fail <= ~self_test_fail;
      if (self_test_start) begin
        cnt <= TEST_CYCLES;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          self_test_done <= 1'b1;
          self_test_fail <= fail_level;
        end
      end
    end
  end
endmodule : self_test_model

`default_nettype wire

// file: verilog/scpi_status_capture_ctrl.sv
/*
  Status reporting and capture control, reached over APB. Commands are
  written to the command register, answers read from the response register.
  Assumes the rest of the device reports pending operations, events,
  self-test results and capture ends synchronously to pclk.
*/
// What this block does
// - Clear-status clears status byte, event status, questionable, operation and error queue.
// - Event enable mask is written as 0..255 and stored as eight bits.
// - Any enabled and set event bit sets summary bit 5 of the status byte.
// - Event enable query returns the stored eight-bit mask.
// - Event status read reports only bits both occurred and enabled.
// - The event status query clears it after the value is returned; a register read leaves it set.
// - Identification gives four fields: maker, model, serial, firmware.
// - Operation-complete sets event bit 0 once all earlier commands finish.
// - Operation-complete query holds new commands until done, then answers ASCII 1.
// - Reset restores defaults, stops capture and trigger, flushes buffered data.
// - Reset leaves status registers, masks and queues unchanged.
// - Service enable mask stored; service request when enabled status bit set.
// - Status byte query returns its bits without clearing any.
// - Self-test query runs the test and answers 0 pass, 1 fail.
// - Wait suspends all later commands until pending operations complete.
// - Abort stops capture in streaming, trigger or sweep operation as soon as no wait or query is pending.
// - After abort the device is manual: streaming, trigger, sweep stopped.
// - Capture mode query reports block, streaming or sweeping; block after reset.
// - When streaming or sweeping stops, block capture resumes.
// - Commands and answers use network port 37001.
`timescale 1ns/1ns
`default_nettype none

`include "scpi_status_capture_ctrl_regs.svh"

module scpi_status_capture_ctrl
  import scpi_status_capture_pkg::*;
#(
  parameter int ERR_DEPTH = 16,
  parameter logic [31:0] IDENT_MAKER = 32'h0000_0A01,
  parameter logic [31:0] IDENT_MODEL = 32'h0000_0B02,
  parameter logic [31:0] IDENT_SERIAL = 32'h0000_0C03,
  parameter logic [31:0] IDENT_FIRMWARE = 32'h0000_0D04
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device status inputs
  input wire logic op_pending,
  input wire logic [7:1] event_in,
  input wire logic error_event,
  input wire logic quest_event,
  input wire logic oper_event,
  // Self-test
  output logic self_test_start,
  input wire logic self_test_done,
  input wire logic self_test_fail,
  // Capture control
  input wire logic stream_stopped,
  input wire logic sweep_stopped,
  output logic [1:0] capture_mode,
  output logic trigger_enable,
  output logic capture_stop,
  output logic defaults_restore,
  output logic buffer_flush,
  // Service request
  output logic service_request
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ERR_DEPTH < 1 || ERR_DEPTH > 255) begin : g_bad_depth
    $error("ERR_DEPTH must lie in 1..255");
  end

  localparam logic [7:0] ERR_MAX = 8'(ERR_DEPTH);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  seq_state_type state, next_state;
  capture_mode_type mode, next_mode;
  logic [7:0] esr, next_esr;
  logic [7:0] ese, next_ese;
  logic [7:0] sre, next_sre;
  logic [7:0] resp, next_resp;
  logic mav, next_mav;
  logic quest_sum, next_quest_sum;
  logic oper_sum, next_oper_sum;
  logic [7:0] err_count, next_err_count;
  logic opc_armed, next_opc_armed;
  logic next_trigger_enable;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_self_test_start;
  logic next_capture_stop;
  logic next_defaults_restore;
  logic next_buffer_flush;
  logic next_service_request;

  // ---------------------------------------------------------------
  // Derived status
  // ---------------------------------------------------------------
  logic access;
  logic take;
  logic cmd_write;
  logic resp_read;
  logic stall;
  logic esb;
  logic [7:0] stb;
  command_type cmd;
  logic [7:0] arg;

  always_comb begin
    access = psel && penable;
    take = access && pready;
    cmd_write = pwrite && (paddr == `OFS_COMMAND);
    resp_read = !pwrite && (paddr == `OFS_RESPONSE);
    // Hold later commands and answers while a wait or query is pending
    stall = (state != SEQ_IDLE) && (cmd_write || resp_read);
    esb = |(esr & ese);
    stb = 8'h00;
    stb[`STB_ERR_QUEUE] = (err_count != 8'h00);
    stb[`STB_QUEST] = quest_sum;
    stb[`STB_MAV] = mav;
    stb[`STB_ESB] = esb;
    stb[`STB_OPER] = oper_sum;
    stb[`STB_RQS] = |(stb & sre);
    cmd = command_type'(pwdata[`CMD_CODE_MSB:`CMD_CODE_LSB]);
    arg = pwdata[`CMD_ARG_MSB:`CMD_ARG_LSB];
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic [7:0] esr_set;
  logic esr_clear;
  logic status_clear;
  logic resp_taken;

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_ese = ese;
    next_sre = sre;
    next_resp = resp;
    next_mav = mav;
    next_opc_armed = opc_armed;
    next_trigger_enable = trigger_enable;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_self_test_start = 1'b0;
    next_capture_stop = 1'b0;
    next_defaults_restore = 1'b0;
    next_buffer_flush = 1'b0;
    esr_set = {event_in, 1'b0};
    esr_clear = 1'b0;
    status_clear = 1'b0;
    resp_taken = 1'b0;

    // APB answer, one wait cycle, stretched while stalled
    if (access && !pready && !stall) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
        `OFS_COMMAND: next_prdata = 32'h0000_0000;
        `OFS_RESPONSE: next_prdata = {24'h00_0000, resp};
        `OFS_STATUS: next_prdata = {19'h0_0000, trigger_enable, mode, service_request,
                                    (state != SEQ_IDLE), stb};
        `OFS_EVENT_ENABLE: next_prdata = {24'h00_0000, ese};
        `OFS_SERVICE_ENABLE: next_prdata = {24'h00_0000, sre};
        `OFS_EVENT_STATUS: next_prdata = {24'h00_0000, esr & ese};
        `OFS_IDENT_MAKER: next_prdata = IDENT_MAKER;
        `OFS_IDENT_MODEL: next_prdata = IDENT_MODEL;
        `OFS_IDENT_SERIAL: next_prdata = IDENT_SERIAL;
        `OFS_IDENT_FIRMWARE: next_prdata = IDENT_FIRMWARE;
        `OFS_NET_PORT: next_prdata = {16'h0000, `NET_PORT_NUMBER};
        default: next_pslverr = 1'b1;
      endcase
    end

    // Reading the answer empties the output queue
    if (take && resp_read) begin
      resp_taken = 1'b1;
    end
    if (resp_taken) begin
      next_mav = 1'b0;
    end

    // Command execution at the completing edge
    if (take && cmd_write) begin
      case (cmd)
        CMD_CLEAR_STATUS: begin
          status_clear = 1'b1;
          esr_clear = 1'b1;
          next_mav = 1'b0;
        end
        CMD_EVENT_ENABLE: next_ese = arg;
        CMD_EVENT_ENABLE_Q: begin
          next_resp = ese;
          next_mav = 1'b1;
        end
        CMD_EVENT_STATUS_Q: begin
          next_resp = esr & ese;
          next_mav = 1'b1;
          esr_clear = 1'b1;
        end
        CMD_IDENT_Q: begin
          next_resp = `ANSWER_IDN_FIELDS;
          next_mav = 1'b1;
        end
        CMD_OP_COMPLETE: next_opc_armed = 1'b1;
        CMD_OP_COMPLETE_Q: next_state = SEQ_OPC_QUERY;
        CMD_RESET: begin
          // Status, masks and queues are left alone
          next_defaults_restore = 1'b1;
          next_buffer_flush = 1'b1;
          next_capture_stop = 1'b1;
          next_trigger_enable = 1'b0;
          next_mode = MODE_BLOCK;
        end
        CMD_SERVICE_ENABLE: next_sre = arg;
        CMD_SERVICE_ENABLE_Q: begin
          next_resp = sre;
          next_mav = 1'b1;
        end
        CMD_STATUS_BYTE_Q: begin
          next_resp = stb;
          next_mav = 1'b1;
        end
        CMD_SELF_TEST_Q: begin
          next_self_test_start = 1'b1;
          next_state = SEQ_SELF_TEST;
        end
        CMD_WAIT: next_state = SEQ_WAIT;
        CMD_ABORT: begin
          next_capture_stop = 1'b1;
          next_trigger_enable = 1'b0;
          next_mode = MODE_BLOCK;
        end
        CMD_CAPTURE_MODE_Q: begin
          next_resp = {6'h00, mode};
          next_mav = 1'b1;
        end
        CMD_START_STREAM: next_mode = MODE_STREAMING;
        CMD_START_SWEEP: next_mode = MODE_SWEEPING;
        CMD_TRIGGER_ON: next_trigger_enable = 1'b1;
        default: next_pslverr = 1'b0;
      endcase
    end

    // End of streaming or sweeping falls back to block
    if ((mode == MODE_STREAMING && stream_stopped) || (mode == MODE_SWEEPING && sweep_stopped)) begin
      next_mode = MODE_BLOCK;
    end

    // Pending operation completion
    if (opc_armed && !op_pending) begin
      esr_set[`ESR_OPC] = 1'b1;
      next_opc_armed = 1'b0;
    end

    case (state)
      SEQ_IDLE: next_state = next_state;
      SEQ_WAIT: begin
        if (!op_pending) begin
          next_state = SEQ_IDLE;
        end
      end
      SEQ_OPC_QUERY: begin
        if (!op_pending) begin
          next_resp = `ANSWER_OPC;
          next_mav = 1'b1;
          next_state = SEQ_IDLE;
        end
      end
      SEQ_SELF_TEST: begin
        if (self_test_done) begin
          next_resp = self_test_fail ? `ANSWER_FAIL : `ANSWER_PASS;
          next_mav = 1'b1;
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase

    // Latched events; a new event wins over a clear
    next_esr = (esr & ~(esr_clear ? 8'hFF : 8'h00)) | esr_set;
    next_quest_sum = (quest_sum && !status_clear) || quest_event;
    next_oper_sum = (oper_sum && !status_clear) || oper_event;
    next_err_count = status_clear ? `RST_ERR_COUNT : err_count;
    if (error_event && next_err_count != ERR_MAX) begin
      next_err_count = next_err_count + 8'h01;
    end

    next_service_request = stb[`STB_RQS];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
      mode <= MODE_BLOCK;
      esr <= `RST_MASK;
      ese <= `RST_MASK;
      sre <= `RST_MASK;
      resp <= `RST_MASK;
      mav <= 1'b0;
      quest_sum <= 1'b0;
      oper_sum <= 1'b0;
      err_count <= `RST_ERR_COUNT;
      opc_armed <= 1'b0;
      trigger_enable <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      self_test_start <= 1'b0;
      capture_stop <= 1'b0;
      defaults_restore <= 1'b0;
      buffer_flush <= 1'b0;
      service_request <= 1'b0;
      capture_mode <= MODE_BLOCK;
    end else begin
      state <= next_state;
      mode <= next_mode;
      esr <= next_esr;
      ese <= next_ese;
      sre <= next_sre;
      resp <= next_resp;
      mav <= next_mav;
      quest_sum <= next_quest_sum;
      oper_sum <= next_oper_sum;
      err_count <= next_err_count;
      opc_armed <= next_opc_armed;
      trigger_enable <= next_trigger_enable;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      self_test_start <= next_self_test_start;
      capture_stop <= next_capture_stop;
      defaults_restore <= next_defaults_restore;
      buffer_flush <= next_buffer_flush;
      service_request <= next_service_request;
      capture_mode <= next_mode;
    end
  end

endmodule : scpi_status_capture_ctrl

`default_nettype wire

// file: verilog/scpi_status_capture_ctrl_regs.svh
/*
  Register offsets, field positions, reset values and constants of the
  status and capture controller.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SCPI_STATUS_CAPTURE_CTRL_REGS_SVH
`define SCPI_STATUS_CAPTURE_CTRL_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_COMMAND 12'h000
`define OFS_RESPONSE 12'h004
`define OFS_STATUS 12'h008
`define OFS_EVENT_ENABLE 12'h00C
`define OFS_SERVICE_ENABLE 12'h010
`define OFS_EVENT_STATUS 12'h014
`define OFS_IDENT_MAKER 12'h018
`define OFS_IDENT_MODEL 12'h01C
`define OFS_IDENT_SERIAL 12'h020
`define OFS_IDENT_FIRMWARE 12'h024
`define OFS_NET_PORT 12'h028

// ---------------------------------------------------------------
// Command word fields
// ---------------------------------------------------------------
`define CMD_CODE_LSB 0
`define CMD_CODE_MSB 4
`define CMD_ARG_LSB 8
`define CMD_ARG_MSB 15

// ---------------------------------------------------------------
// Status byte and event status bit positions
// ---------------------------------------------------------------
`define STB_ERR_QUEUE 2
`define STB_QUEST 3
`define STB_MAV 4
`define STB_ESB 5
`define STB_RQS 6
`define STB_OPER 7
`define ESR_OPC 0

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define STAT_BUSY 8
`define STAT_SRQ 9
`define STAT_MODE_LSB 10
`define STAT_MODE_MSB 11
`define STAT_TRIG 12

// ---------------------------------------------------------------
// Reset values and fixed answers
// ---------------------------------------------------------------
`define RST_MASK 8'h00
`define RST_ERR_COUNT 8'h00
`define ANSWER_OPC 8'h31
`define ANSWER_PASS 8'h00
`define ANSWER_FAIL 8'h01
`define ANSWER_IDN_FIELDS 8'h04
`define NET_PORT_NUMBER 16'h9089

`endif

// file: verilog/scpi_status_capture_pkg.sv
/*
  Types of the status and capture controller: command codes, sequencer
  states and capture modes.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package scpi_status_capture_pkg;

  typedef enum logic [4:0] {
    CMD_NONE = 5'h00,
    CMD_CLEAR_STATUS = 5'h01,
    CMD_EVENT_ENABLE = 5'h02,
    CMD_EVENT_ENABLE_Q = 5'h03,
    CMD_EVENT_STATUS_Q = 5'h04,
    CMD_IDENT_Q = 5'h05,
    CMD_OP_COMPLETE = 5'h06,
    CMD_OP_COMPLETE_Q = 5'h07,
    CMD_RESET = 5'h08,
    CMD_SERVICE_ENABLE = 5'h09,
    CMD_SERVICE_ENABLE_Q = 5'h0A,
    CMD_STATUS_BYTE_Q = 5'h0B,
    CMD_SELF_TEST_Q = 5'h0C,
    CMD_WAIT = 5'h0D,
    CMD_ABORT = 5'h0E,
    CMD_CAPTURE_MODE_Q = 5'h0F,
    CMD_START_STREAM = 5'h10,
    CMD_START_SWEEP = 5'h11,
    CMD_TRIGGER_ON = 5'h12
  } command_type;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_OPC_QUERY = 2'b10,
    SEQ_SELF_TEST = 2'b11
  } seq_state_type;

  typedef enum logic [1:0] {
    MODE_BLOCK = 2'b00,
    MODE_STREAMING = 2'b01,
    MODE_SWEEPING = 2'b10
  } capture_mode_type;

endpackage : scpi_status_capture_pkg

`default_nettype wire
